// *** design/ecs_defines.vh ***
// Constants for the memory interface clock select and clock output block.
// Assumes a 32-bit byte address on the register port and one 10 MHz clock.
`ifndef ECS_DEFINES_VH
`define ECS_DEFINES_VH

// Address window of the block
`define ECS_BASE_ADDR      32'h019c0200
`define ECS_LAST_ADDR      32'h019c02ff
// Register byte addresses
`define ECS_DEVCONF_ADDR   32'h019c0200
`define ECS_GLBCTL_ADDR    32'h019c0204
`define ECS_OSCDIV_ADDR    32'h019c0208
`define ECS_STATUS_ADDR    32'h019c020c

// Configuration register field and reset
`define ECS_SRC_BIT        4
`define ECS_DEVCONF_RST    1'h0

// Global control fields and reset values
`define ECS_FS_EN_BIT      0
`define ECS_HS_EN_BIT      1
`define ECS_GPIO_SEL_BIT   2
`define ECS_GPIO_OUT_BIT   3
`define ECS_GPIO_OE_BIT    4
`define ECS_FS_EN_RST      1'h1
`define ECS_HS_EN_RST      1'h1
`define ECS_GPIO_SEL_RST   1'h0
`define ECS_GPIO_OUT_RST   1'h0
`define ECS_GPIO_OE_RST    1'h0

// Divider register fields and reset values
`define ECS_DIV_LSB        0
`define ECS_DIV_MSB        4
`define ECS_DIV_EN_BIT     15
`define ECS_DIV_RST        5'h07
`define ECS_DIV_EN_RST     1'h1

// Status register fields
`define ECS_ST_STRAP_BIT   0
`define ECS_ST_X4_BIT      1
`define ECS_ST_SQUARE_BIT  2
`define ECS_ST_RSVD_BIT    3
`define ECS_ST_GPIN_BIT    4
`define ECS_ST_SRC_BIT     5

// Multiplier ratios of the early variant
`define ECS_MULT_BYPASS    3'h1
`define ECS_MULT_PLL       3'h4

`endif

// *** design/ecs_clock_select.v ***
// Clock source select, clock output gating and divided clock for the
// memory interface. Assumes pins arrive asynchronously and a register
// master that follows the plain strobe protocol with no wait states.
`timescale 1ns/10ps
`include "ecs_defines.vh"

module ecs_clock_select #(
	parameter LATE_VARIANT = 1,	// 1: strap selects input clock type
	parameter DIV_WIDTH    = 5	// Width of the divider ratio field
) (
	input  wire        core_clk,
	input  wire        reset_n,
	input  wire [31:0] reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_write,
	input  wire        reg_read,
	output reg  [31:0] reg_rdata,
	input  wire        external_memif_clock_pin,
	input  wire        clock_mode_strap,
	output reg         memif_input_clock,
	output reg         generator_clock_three,
	output reg         fullspeed_clock_out,
	output reg         halfspeed_pin_out,
	output reg         halfspeed_pin_oe,
	input  wire        halfspeed_pin_in,
	output reg         divided_clock_out,
	output reg  [2:0]  cpu_clock_multiplier,
	output reg         square_input_clock,
	output reg         strap_reserved_seen
);

	// Software state
	reg                 src_sel_reg;	// Memory clock source select
	reg                 fs_en_reg;	// Fullspeed output enable
	reg                 hs_en_reg;	// Halfspeed output enable
	reg                 gpio_sel_reg;	// Halfspeed pin used as GPIO
	reg                 gpio_out_reg;	// GPIO drive value
	reg                 gpio_oe_reg;	// GPIO drive enable
	reg [DIV_WIDTH-1:0] div_ratio_reg;	// Divider ratio minus one
	reg                 div_en_reg;	// Divider enable

	// Synchronisers for pins
	reg                 ext_meta_reg;	// First stage, external clock
	reg                 ext_sync_reg;	// Second stage, external clock
	reg                 strap_meta_reg;	// First stage, strap
	reg                 strap_sync_reg;	// Second stage, strap
	reg                 gpin_meta_reg;	// First stage, GPIO input
	reg                 gpin_sync_reg;	// Second stage, GPIO input

	// Strap capture
	reg                 strap_done_reg;	// Strap taken after release
	reg                 strap_val_reg;	// Captured strap level

	// Clock generation
	reg                 fs_tog_reg;	// Toggles every cycle
	reg                 hs_tog_reg;	// Toggles every second cycle
	reg [1:0]           g3_cnt_reg;	// Divider for generator clock three
	reg [DIV_WIDTH-1:0] div_cnt_reg;	// Divider counter
	reg                 div_tog_reg;	// Divided clock level

	// Decode helpers
	wire                in_window;	// Address inside block window
	reg  [31:0]         rd_word;	// Read value before register

	// Window decode, every address in range belongs to the block
	assign in_window = (reg_addr >= `ECS_BASE_ADDR) && (reg_addr <= `ECS_LAST_ADDR);

	// Register writes; only defined bits are stored
	always @(posedge core_clk) begin
		if (!reset_n) begin
			src_sel_reg   <= `ECS_DEVCONF_RST;
			fs_en_reg     <= `ECS_FS_EN_RST;
			hs_en_reg     <= `ECS_HS_EN_RST;
			gpio_sel_reg  <= `ECS_GPIO_SEL_RST;
			gpio_out_reg  <= `ECS_GPIO_OUT_RST;
			gpio_oe_reg   <= `ECS_GPIO_OE_RST;
			div_ratio_reg <= `ECS_DIV_RST;
			div_en_reg    <= `ECS_DIV_EN_RST;
		end else if (reg_write && in_window) begin
			case (reg_addr)
				`ECS_DEVCONF_ADDR: begin
					// Unused bits are expected zero and are dropped
					src_sel_reg <= reg_wdata[`ECS_SRC_BIT];
				end
				`ECS_GLBCTL_ADDR: begin
					fs_en_reg    <= reg_wdata[`ECS_FS_EN_BIT];
					hs_en_reg    <= reg_wdata[`ECS_HS_EN_BIT];
					gpio_sel_reg <= reg_wdata[`ECS_GPIO_SEL_BIT];
					gpio_out_reg <= reg_wdata[`ECS_GPIO_OUT_BIT];
					gpio_oe_reg  <= reg_wdata[`ECS_GPIO_OE_BIT];
				end
				`ECS_OSCDIV_ADDR: begin
					div_ratio_reg <= reg_wdata[`ECS_DIV_LSB +: DIV_WIDTH];
					div_en_reg    <= reg_wdata[`ECS_DIV_EN_BIT];
				end
				default: begin
					// Other addresses in the window ignore writes
				end
			endcase
		end
	end

	// Read multiplexer; reserved bits and unmapped words read zero
	always @* begin
		rd_word = 32'h00000000;
		case (reg_addr)
			`ECS_DEVCONF_ADDR: begin
				rd_word[`ECS_SRC_BIT] = src_sel_reg;
			end
			`ECS_GLBCTL_ADDR: begin
				rd_word[`ECS_FS_EN_BIT]    = fs_en_reg;
				rd_word[`ECS_HS_EN_BIT]    = hs_en_reg;
				rd_word[`ECS_GPIO_SEL_BIT] = gpio_sel_reg;
				rd_word[`ECS_GPIO_OUT_BIT] = gpio_out_reg;
				rd_word[`ECS_GPIO_OE_BIT]  = gpio_oe_reg;
			end
			`ECS_OSCDIV_ADDR: begin
				rd_word[`ECS_DIV_LSB +: DIV_WIDTH] = div_ratio_reg;
				rd_word[`ECS_DIV_EN_BIT]           = div_en_reg;
			end
			`ECS_STATUS_ADDR: begin
				rd_word[`ECS_ST_STRAP_BIT]  = strap_val_reg;
				rd_word[`ECS_ST_X4_BIT]     = (cpu_clock_multiplier == `ECS_MULT_PLL);
				rd_word[`ECS_ST_SQUARE_BIT] = square_input_clock;
				rd_word[`ECS_ST_RSVD_BIT]   = strap_reserved_seen;
				rd_word[`ECS_ST_GPIN_BIT]   = gpin_sync_reg;
				rd_word[`ECS_ST_SRC_BIT]    = memif_input_clock;
			end
			default: begin
				rd_word = 32'h00000000;
			end
		endcase
	end

	// Read data stand for the one cycle after the strobe
	always @(posedge core_clk) begin
		if (!reset_n) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_read && in_window) begin
			reg_rdata <= rd_word;
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	// Two-flop synchronisers for all pin inputs
	// They keep sampling through reset, so the strap level is already
	// settled in the second stage when reset lets go
	always @(posedge core_clk) begin
		ext_meta_reg   <= external_memif_clock_pin;
		ext_sync_reg   <= ext_meta_reg;
		strap_meta_reg <= clock_mode_strap;
		strap_sync_reg <= strap_meta_reg;
		gpin_meta_reg  <= halfspeed_pin_in;
		gpin_sync_reg  <= gpin_meta_reg;
	end

	// Strap is taken once, at the first edge after release
	always @(posedge core_clk) begin
		if (!reset_n) begin
			strap_done_reg <= 1'h0;
			strap_val_reg  <= 1'h1;
		end else if (!strap_done_reg) begin
			strap_done_reg <= 1'h1;
			strap_val_reg  <= strap_sync_reg;
		end else begin
			strap_done_reg <= strap_done_reg;
			strap_val_reg  <= strap_val_reg;
		end
	end

	// Strap meaning depends on the variant
	always @(posedge core_clk) begin
		if (!reset_n) begin
			cpu_clock_multiplier <= `ECS_MULT_PLL;
			square_input_clock   <= 1'h1;
			strap_reserved_seen  <= 1'h0;
		end else if (LATE_VARIANT == 0) begin
			// Early parts: x1 bypass or x4 multiplier
			cpu_clock_multiplier <= strap_sync_reg ? `ECS_MULT_PLL : `ECS_MULT_BYPASS;
			square_input_clock   <= 1'h1;
			strap_reserved_seen  <= 1'h0;
		end else begin
			// Late parts: low level is reserved; it is flagged and also clears the square flag
			cpu_clock_multiplier <= `ECS_MULT_BYPASS;
			square_input_clock   <= strap_sync_reg;
			strap_reserved_seen  <= strap_reserved_seen | ~strap_sync_reg;
		end
	end

	// Internal generator clocks and the selected memory clock
	always @(posedge core_clk) begin
		if (!reset_n) begin
			fs_tog_reg            <= 1'h0;
			hs_tog_reg            <= 1'h0;
			g3_cnt_reg            <= 2'h0;
			generator_clock_three <= 1'h0;
			memif_input_clock     <= 1'h0;
		end else begin
			fs_tog_reg            <= ~fs_tog_reg;
			hs_tog_reg            <= fs_tog_reg ? ~hs_tog_reg : hs_tog_reg;
			g3_cnt_reg            <= g3_cnt_reg + 2'h1;
			generator_clock_three <= g3_cnt_reg[1];
			// Source 0 is generator clock three, 1 the external pin
			memif_input_clock <= src_sel_reg ? ext_sync_reg : g3_cnt_reg[1];
		end
	end

	// Output pins: fullspeed gated, halfspeed shared with GPIO
	always @(posedge core_clk) begin
		if (!reset_n) begin
			fullspeed_clock_out <= 1'h0;
			halfspeed_pin_out   <= 1'h0;
			halfspeed_pin_oe    <= 1'h0;
		end else begin
			// Disabled output holds low
			fullspeed_clock_out <= fs_en_reg & ~fs_tog_reg;
			if (gpio_sel_reg) begin
				// Pin programmed as general purpose line two
				halfspeed_pin_out <= gpio_out_reg;
				halfspeed_pin_oe  <= gpio_oe_reg;
			end else begin
				// Clock function: enable bit gates the clock
				halfspeed_pin_out <= hs_en_reg & ~hs_tog_reg;
				halfspeed_pin_oe  <= hs_en_reg;
			end
		end
	end

	// Third output: toggles every ratio plus one cycles
	always @(posedge core_clk) begin
		if (!reset_n) begin
			div_cnt_reg       <= {DIV_WIDTH{1'b0}};
			div_tog_reg       <= 1'h0;
			divided_clock_out <= 1'h0;
		end else if (!div_en_reg) begin
			div_cnt_reg       <= {DIV_WIDTH{1'b0}};
			div_tog_reg       <= 1'h0;
			divided_clock_out <= 1'h0;
		end else if (div_cnt_reg >= div_ratio_reg) begin
			div_cnt_reg       <= {DIV_WIDTH{1'b0}};
			div_tog_reg       <= ~div_tog_reg;
			divided_clock_out <= ~div_tog_reg;
		end else begin
			div_cnt_reg       <= div_cnt_reg + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
			div_tog_reg       <= div_tog_reg;
			divided_clock_out <= div_tog_reg;
		end
	end

endmodule // ecs_clock_select

// *** tb/ecs_clock_select_monitor.sv ***
// Checker for the clock select block, watching its top ports only.
// Assumes a bind from the bench and a synchronous active-low reset.
`timescale 1ns/10ps
module ecs_clock_select_monitor #(
	parameter LATE_VARIANT = 1	// Follows the bound design's variant
) (
	input wire        core_clk,
	input wire        reset_n,
	input wire [31:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire        reg_write,
	input wire        reg_read,
	input wire [31:0] reg_rdata,
	input wire        clock_mode_strap,
	input wire        fullspeed_clock_out,
	input wire        halfspeed_pin_out,
	input wire        halfspeed_pin_oe,
	input wire [2:0]  cpu_clock_multiplier,
	input wire        square_input_clock,
	input wire        strap_reserved_seen
);
	reg [4:0] ctl_reg; // Mirror of the global control bits
	// Mirror control writes so output gating can be judged
	always @(posedge core_clk) begin
		if (!reset_n)
			ctl_reg <= 5'h03;
		else if (reg_write && reg_addr == 32'h019c0204)
			ctl_reg <= reg_wdata[4:0];
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// Control unchanged long enough for outputs to follow
	sequence ctl_settled;
		$past(reset_n, 3) && ctl_reg == $past(ctl_reg) && ctl_reg == $past(ctl_reg, 2);
	endsequence
	// Strap level unchanged long enough to pass the synchroniser and decode
	sequence strap_steady;
		$past(reset_n, 4) && clock_mode_strap == $past(clock_mode_strap)
			&& clock_mode_strap == $past(clock_mode_strap, 2)
			&& clock_mode_strap == $past(clock_mode_strap, 3);
	endsequence
	// Read data only in the cycle after a read
	chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside a read");
	chk_cfg_unused: assert property ($past(reg_read) && $past(reg_addr) == 32'h019c0200
		|-> (reg_rdata & 32'hffffffef) == 32'h0) else $error("unused config bits set");
	chk_window_out: assert property ($past(reg_read) && ($past(reg_addr) < 32'h019c0200
		|| $past(reg_addr) > 32'h019c02ff) |-> reg_rdata == 32'h0)
		else $error("read outside window not zero");
	chk_mult_late: assert property ($past(reset_n) && LATE_VARIANT != 0
		|-> cpu_clock_multiplier == 3'h1) else $error("multiplier wrong");
	chk_mult_early: assert property (strap_steady ##0 LATE_VARIANT == 0
		|-> cpu_clock_multiplier == (clock_mode_strap ? 3'h4 : 3'h1))
		else $error("early multiplier wrong");
	chk_square_strap: assert property (strap_steady
		|-> square_input_clock == (LATE_VARIANT == 0 || clock_mode_strap))
		else $error("square flag wrong");
	chk_seen_sticky: assert property (strap_reserved_seen |=> strap_reserved_seen)
		else $error("reserved flag dropped");
	chk_seen_set: assert property ($past(reset_n) && !square_input_clock
		|-> ##[0:2] strap_reserved_seen) else $error("reserved flag not set");
	chk_fs_off: assert property (ctl_settled ##0 !ctl_reg[0] |-> !fullspeed_clock_out)
		else $error("fullspeed out while disabled");
	chk_fs_run: assert property (ctl_settled ##0 ctl_reg[0]
		|-> fullspeed_clock_out != $past(fullspeed_clock_out)) else $error("fullspeed stuck");
	chk_hs_clock: assert property (ctl_settled ##0 !ctl_reg[2]
		|-> halfspeed_pin_oe == ctl_reg[1] && (ctl_reg[1] || !halfspeed_pin_out))
		else $error("halfspeed gating wrong");
	chk_hs_gpio: assert property (ctl_settled ##0 ctl_reg[2]
		|-> halfspeed_pin_oe == ctl_reg[4] && halfspeed_pin_out == ctl_reg[3])
		else $error("general io pin wrong");
endmodule // ecs_clock_select_monitor

// *** tb/ecs_clock_select_test.sv ***
// Bench for the clock select block: registers, clock outputs, strap.
// Assumes the design and the monitor are compiled before this file.
`timescale 1ns/10ps
module ecs_clock_select_test;
	reg         core_clk, reset_n, reg_write, reg_read, ext_pin, strap, hs_in, strap_e;
	reg  [31:0] reg_addr, reg_wdata;
	wire [31:0] reg_rdata;
	wire        mic, g3, fs, hso, hsoe, dco, sq, seen;
	wire [2:0]  mult, mult_e;
	reg         last;   // Previous divided clock sample
	integer     num_errors, checks, cyc, n_fs, n_mic, n_dc, n_hs, n_g3;
	ecs_clock_select i_ecs_clock_select (.core_clk(core_clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .external_memif_clock_pin(ext_pin),
		.clock_mode_strap(strap), .memif_input_clock(mic), .generator_clock_three(g3),
		.fullspeed_clock_out(fs), .halfspeed_pin_out(hso), .halfspeed_pin_oe(hsoe),
		.halfspeed_pin_in(hs_in), .divided_clock_out(dco), .cpu_clock_multiplier(mult),
		.square_input_clock(sq), .strap_reserved_seen(seen));
	// Early-variant copy; its own strap may legally sit at either level
	ecs_clock_select #(.LATE_VARIANT(0)) i_ecs_clock_select_early (.core_clk(core_clk),
		.reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(),
		.external_memif_clock_pin(ext_pin), .clock_mode_strap(strap_e),
		.memif_input_clock(), .generator_clock_three(), .fullspeed_clock_out(),
		.halfspeed_pin_out(), .halfspeed_pin_oe(), .halfspeed_pin_in(hs_in),
		.divided_clock_out(), .cpu_clock_multiplier(mult_e), .square_input_clock(),
		.strap_reserved_seen());
	// Clock of 100 ns
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// Hang guard
	always @(posedge core_clk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			num_errors = num_errors + 1;
			give_verdict;
		end
	end
	task give_verdict;
		begin
			$display("checks %0d num_errors %0d", checks, num_errors);
			if (num_errors == 0 && checks > 0) $display("*** PASS ***");
			else $display("*** FAIL ***");
			$finish;
		end
	endtask
	task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
		begin
			checks = checks + 1;
			if (g !== e) begin
				num_errors = num_errors + 1;
				$display("ERROR %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	// One-cycle write, then one idle edge
	task wr(input [31:0] a, input [31:0] d);
		begin
			reg_addr <= a;
			reg_wdata <= d;
			reg_write <= 1'b1;
			@(posedge core_clk);
			reg_write <= 1'b0;
			@(posedge core_clk);
		end
	endtask
	// Read, compare masked data in the answer cycle
	task rd(input [31:0] a, input [31:0] m, input [31:0] e, input [63:0] nm);
		begin
			reg_addr <= a;
			reg_read <= 1'b1;
			@(posedge core_clk);
			reg_read <= 1'b0;
			#1 chk(nm, e, reg_rdata & m);
			@(posedge core_clk);
		end
	endtask
	// Count highs and divided clock toggles over 24 cycles
	task sample;
		begin
			n_fs = 0;
			n_mic = 0;
			n_dc = 0;
			n_hs = 0;
			n_g3 = 0;
			#1 last = dco;
			repeat (24) begin
				@(posedge core_clk);
				#1 n_fs = n_fs + fs;
				n_mic = n_mic + mic;
				n_hs = n_hs + hso;
				n_g3 = n_g3 + g3;
				n_dc = n_dc + (dco != last);
				last = dco;
			end
			@(posedge core_clk);
		end
	endtask
	task t_reset;
		begin
			rd(32'h019c0200, 32'hffffffff, 32'h0, "cfg");
			rd(32'h019c0204, 32'h1f, 32'h3, "ctl");
			rd(32'h019c0208, 32'h801f, 32'h8007, "div");
			chk("seen", 32'h0, seen);
			rd(32'h019c020c, 32'h0f, 32'h5, "status");
		end
	endtask
	task t_cfg;
		begin
			wr(32'h019c0200, 32'h00000010);
			rd(32'h019c0200, 32'hffffffff, 32'h10, "cfgrb");
			sample;
			chk("pin0", 32'h0, n_mic);
			ext_pin <= 1'b1;
			repeat (3) @(posedge core_clk);
			sample;
			chk("pin1", 32'd24, n_mic);
			wr(32'h019c0200, 32'h0);
			sample;
			chk("gen3", 32'd12, n_mic);
			chk("g3run", 32'd12, n_g3);
		end
	endtask
	task t_window;
		begin
			wr(32'h019c0304, 32'h0);
			rd(32'h019c0204, 32'h1f, 32'h3, "alias");
			wr(32'h019c0210, 32'hff);
			rd(32'h019c0210, 32'hffffffff, 32'h0, "hole");
			rd(32'h019c0304, 32'hffffffff, 32'h0, "outside");
		end
	endtask
	task t_out;
		begin
			wr(32'h019c0204, 32'h0);
			sample;
			chk("fsoff", 32'h0, n_fs);
			chk("hsoe", 32'h0, hsoe);
			chk("hsoff", 32'h0, n_hs);
			wr(32'h019c0204, 32'h1c);
			hs_in <= 1'b1;
			sample;
			chk("gpio", 32'h3, {hso, hsoe});
			chk("gpiohold", 32'd24, n_hs);
			rd(32'h019c020c, 32'h10, 32'h10, "gpin");
			wr(32'h019c0204, 32'h3);
			sample;
			chk("fson", 32'd12, n_fs);
			chk("hson", 32'h1, hsoe);
			chk("hsrun", 32'd12, n_hs);
		end
	endtask
	task t_div;
		begin
			wr(32'h019c0208, 32'h8002);
			sample;
			chk("divtog", 32'd8, n_dc);
			wr(32'h019c0208, 32'h0002);
			sample;
			chk("divoff", 32'h0, n_dc);
			chk("dcolow", 32'h0, dco);
		end
	endtask
	task t_strap;
		begin
			strap_e <= 1'b0;
			repeat (6) @(posedge core_clk);
			chk("bypass", 32'h1, mult_e);
			strap_e <= 1'b1;
			repeat (6) @(posedge core_clk);
			chk("pll", 32'h4, mult_e);
			chk("square", 32'h2, {sq, seen});
			chk("mult", 32'h1, mult);
		end
	endtask
	// Main sequence
	initial begin
		{reset_n, reg_write, reg_read, ext_pin, hs_in} = 5'h0;
		strap = 1'b1;
		strap_e = 1'b1;
		reg_addr = 32'h0;
		reg_wdata = 32'h0;
		{num_errors, checks, cyc} = 96'h0;
		repeat (12) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		t_reset;
		t_cfg;
		t_window;
		t_out;
		t_div;
		t_strap;
		give_verdict;
	end
endmodule // ecs_clock_select_test
bind ecs_clock_select ecs_clock_select_monitor #(.LATE_VARIANT(LATE_VARIANT))
	i_ecs_clock_select_monitor (
	.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.clock_mode_strap(clock_mode_strap), .fullspeed_clock_out(fullspeed_clock_out),
	.halfspeed_pin_out(halfspeed_pin_out), .halfspeed_pin_oe(halfspeed_pin_oe),
	.cpu_clock_multiplier(cpu_clock_multiplier), .square_input_clock(square_input_clock),
	.strap_reserved_seen(strap_reserved_seen));
